// [dpc_pkg.sv]
// shared constants and carriers for the dual-port memory host controller
package dpc_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // priority set-up lead in ns and in cycles at 40 MHz (least time, rounded up)
  localparam int CLK_NS = 25;
  localparam int APS_NS = 5;
  localparam int APS_CYC = (APS_NS + CLK_NS - 1) / CLK_NS;
  // cycles the strobe stays active and cycles address leads the strobe
  localparam int STROBE_CYC = 2;
  localparam int SETUP_CYC = APS_CYC + 1;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpc_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              oe_n;
    logic              rw;
    logic [ADDR_W-1:0] addr;
  } dpc_pins_t;
endpackage : dpc_pkg

// [dpc_host.sv]
// one-port host controller that drives a dual-port memory port and honours its conflict flag
// Contract
// - Host holds address and select until flag settles, then writes.
// - One master decides flags for a width-expanded array.
// - Host receiving the flag stalls until it releases.
// - System may OR both flags as illegal-access interrupt.
// - Earlier port must lead by the priority set-up time.
`timescale 1ns/1ps
`default_nettype none
module dpc_host #(
  parameter int ADDR_W = dpc_pkg::ADDR_W,
  parameter int DATA_W = dpc_pkg::DATA_W
) (
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  input  wire logic               req_valid_in,
  input  wire dpc_pkg::dpc_req_t  req_in,
  output logic                    req_ready_out,
  output logic                    done_out,
  output logic [DATA_W-1:0]       rdata_out,
  output logic                    conflict_out,
  output dpc_pkg::dpc_pins_t      pins_out,
  output logic [DATA_W-1:0]       data_out,
  output logic                    data_oe_out,
  input  wire logic [DATA_W-1:0]  data_in,
  input  wire logic               conflict_flag_n_in
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STALL, ST_STROBE, ST_DONE} dpc_state_t;

  dpc_state_t        state;
  logic [1:0]        count;
  dpc_pkg::dpc_req_t cur;

  // sequencer: select and address first, wait for the flag to settle, then strobe
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ST_IDLE;
      count <= 2'h0;
      cur   <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (req_valid_in)
          begin
            cur   <= req_in;
            count <= 2'h0;
            state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          count <= count + 2'h1;
          if (count == 2'(dpc_pkg::SETUP_CYC - 1))
          begin
            count <= 2'h0;
            state <= conflict_flag_n_in ? ST_STROBE : ST_STALL;
          end
        end
        ST_STALL:
        begin
          if (conflict_flag_n_in)
            state <= ST_STROBE;
        end
        ST_STROBE:
        begin
          count <= count + 2'h1;
          if (!conflict_flag_n_in)
          begin
            // flag raced in mid-strobe: abandon and retry once released
            count <= 2'h0;
            state <= ST_STALL;
          end
          else if (count == 2'(dpc_pkg::STROBE_CYC - 1))
            state <= ST_DONE;
        end
        ST_DONE:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // pin drive: select held through setup, stall and strobe so arbitration stays stable
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pins_out    <= '{sel_n: 1'b1, oe_n: 1'b1, rw: 1'b1, addr: '0};
      data_out    <= '0;
      data_oe_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          pins_out.sel_n <= ~req_valid_in;
          pins_out.rw    <= 1'b1;
          pins_out.oe_n  <= 1'b1;
          data_oe_out    <= 1'b0;
          if (req_valid_in)
          begin
            pins_out.addr <= req_in.addr;
            data_out      <= req_in.wdata;
          end
        end
        ST_SETUP, ST_STALL:
        begin
          pins_out.rw   <= 1'b1;
          pins_out.oe_n <= 1'b1;
          data_oe_out   <= 1'b0;
          if ((state == ST_STALL && conflict_flag_n_in) ||
              (state == ST_SETUP && count == 2'(dpc_pkg::SETUP_CYC - 1) && conflict_flag_n_in))
          begin
            pins_out.rw   <= ~cur.write;
            pins_out.oe_n <= cur.write;
            data_oe_out   <= cur.write;
          end
        end
        ST_STROBE:
        begin
          if (!conflict_flag_n_in || count == 2'(dpc_pkg::STROBE_CYC - 1))
          begin
            pins_out.rw   <= 1'b1;
            pins_out.oe_n <= 1'b1;
            data_oe_out   <= 1'b0;
          end
          if (count == 2'(dpc_pkg::STROBE_CYC - 1) && conflict_flag_n_in)
            pins_out.sel_n <= 1'b1;
        end
        default:
        begin
          pins_out.sel_n <= 1'b1;
          pins_out.rw    <= 1'b1;
          pins_out.oe_n  <= 1'b1;
          data_oe_out    <= 1'b0;
        end
      endcase
    end
  end

  // results: read data captured on the last strobe cycle, only with the flag high
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_out <= '0;
      done_out  <= 1'b0;
    end
    else
    begin
      done_out <= (state == ST_STROBE) && conflict_flag_n_in &&
                  (count == 2'(dpc_pkg::STROBE_CYC - 1));
      if (state == ST_STROBE && conflict_flag_n_in && !cur.write &&
          count == 2'(dpc_pkg::STROBE_CYC - 1))
        rdata_out <= data_in;
    end
  end

  // ready and conflict status, both registered
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      req_ready_out <= 1'b0;
      conflict_out  <= 1'b0;
    end
    else
    begin
      req_ready_out <= (state == ST_IDLE && !req_valid_in) || state == ST_DONE;
      conflict_out  <= (state != ST_IDLE) && !conflict_flag_n_in;
    end
  end

  a_strobe_after_setup: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(pins_out.rw) |-> $past(pins_out.sel_n, 2) == 1'b0)
    else $error("write strobe began without select held first");

  a_stall_on_flag: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_STALL && !conflict_flag_n_in) |=> pins_out.rw && pins_out.oe_n)
    else $error("strobe issued while conflict flag low");

  a_idle_deselect: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_DONE) |=> pins_out.sel_n && !data_oe_out)
    else $error("port left selected after transfer");

  a_write_drives_data: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !pins_out.rw |-> data_oe_out && pins_out.oe_n && !pins_out.sel_n)
    else $error("write strobe without data drive");

  a_read_no_drive: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !pins_out.oe_n |-> !data_oe_out && pins_out.rw)
    else $error("host drives data while device output enabled");

  a_done_flag_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
    done_out |-> $past(conflict_flag_n_in))
    else $error("transfer completed under conflict flag");

  a_addr_stable: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!pins_out.sel_n && !$past(pins_out.sel_n)) |-> $stable(pins_out.addr))
    else $error("address changed while selected");

  a_conflict_report: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_STALL && !conflict_flag_n_in) |=> conflict_out)
    else $error("conflict not reported");

endmodule : dpc_host
`default_nettype wire

// [dpc_mem_model.sv]
// behavioural dual-port memory: left port faces the host, right port is driven by the bench
`timescale 1ns/1ps
`default_nettype none
module dpc_mem_model (
  input  wire dpc_pkg::dpc_pins_t  pins_in,
  input  wire logic [7:0]          data_in,
  input  wire logic                data_oe_in,
  input  wire logic                rsel_n_in,
  input  wire logic [10:0]         raddr_in,
  output logic [7:0]               data_out,
  output logic                     flag_n_out
);
  logic [7:0] mem [0:2047];
  logic [7:0] last = 8'h00;
  logic       left_first = 1'b1;
  logic       drv;
  // order of arrival decides, select and address only
  always @(negedge pins_in.sel_n) left_first = rsel_n_in;
  always @(negedge rsel_n_in) if (!pins_in.sel_n) left_first = 1'b1;
  // only the left flag can fall, so both are never low
  assign flag_n_out = !(!pins_in.sel_n && !rsel_n_in && pins_in.addr == raddr_in && !left_first);
  // a flagged write leaves the array alone
  always @*
  begin
    if (!pins_in.sel_n && !pins_in.rw && flag_n_out && data_oe_in) mem[pins_in.addr] = data_in;
  end
  // released pins show the inverse, flagged reads are garbage
  assign drv = !pins_in.sel_n && pins_in.rw && !pins_in.oe_n;
  always @* if (drv) last = mem[pins_in.addr];
  assign data_out = (drv && flag_n_out) ? mem[pins_in.addr] : ~last;
endmodule : dpc_mem_model
`default_nettype wire

// [dpc_host_tb.sv]
// self-checking bench for one host port against the dual-port memory model
`timescale 1ns/1ps
`default_nettype none
module dpc_host_tb;
  logic               clock_in = 1'b0;
  logic               rstn_in = 1'b0;
  logic               req_valid = 1'b0;
  dpc_pkg::dpc_req_t  req = '0;
  logic               req_ready, done, conflict, data_oe, flag_n, got_done;
  logic               rsel_n = 1'b1;
  logic [10:0]        raddr = 11'h000;
  logic [7:0]         rdata, wdata, mdata;
  dpc_pkg::dpc_pins_t pins;
  logic [7:0]         shadow [0:2047];
  logic [10:0]        used [$];
  logic [10:0]        a;
  int                 num_errors = 0;
  int                 checks = 0;

  dpc_host u_dpc_host (.clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .done_out(done), .rdata_out(rdata),
    .conflict_out(conflict), .pins_out(pins), .data_out(wdata), .data_oe_out(data_oe),
    .data_in(mdata), .conflict_flag_n_in(flag_n));
  dpc_mem_model u_dpc_mem_model (.pins_in(pins), .data_in(wdata), .data_oe_in(data_oe),
    .rsel_n_in(rsel_n), .raddr_in(raddr), .data_out(mdata), .flag_n_out(flag_n));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // expected read value from the bench's own copy of the array
  function automatic logic [7:0] expect_rd(input logic [10:0] ad);
    return shadow[ad];
  endfunction : expect_rd

  // offer one request once idle, drop it after the taking edge, wait bounded for done
  task automatic xfer(input logic wr, input logic [10:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    got_done = 1'b0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge clock_in);
      #2;
      n++;
    end
    // a host that never becomes ready is a hang, counted as a mismatch
    if (n >= 50) chk(8'h00, 8'hFF);
    req = '{write: wr, addr: ad, wdata: d};
    req_valid = 1'b1;
    @(posedge clock_in);
    #2;
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clock_in);
      #2;
      n++;
    end
    if (n >= 400) chk(8'h00, 8'hFF);
    if (wr) shadow[ad] = d;
    got_done = 1'b1;
  endtask : xfer

  task automatic end_sim();
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // watchdog: roughly fifteen times the expected run of about 545 cycles
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hba3c));
    repeat (4) @(posedge clock_in);
    #2;
    chk({7'h00, pins.sel_n}, 8'h01);
    chk({7'h00, data_oe}, 8'h00);
    rstn_in = 1'b1;
    // corner addresses first, then random traffic
    used = '{11'h000, 11'h7FF};
    xfer(1'b1, 11'h000, 8'h3C);
    xfer(1'b1, 11'h7FF, 8'hC3);
    for (int i = 0; i < 40; i++)
    begin
      a = 11'($urandom);
      used.push_back(a);
      xfer(1'b1, a, 8'($urandom));
    end
    foreach (used[i])
    begin
      xfer(1'b0, used[i], 8'h00);
      chk(rdata, expect_rd(used[i]));
    end
    // right port sits on the address first: left write must stall then land
    a = used[5];
    raddr = a;
    rsel_n = 1'b0;
    fork
      xfer(1'b1, a, ~expect_rd(a));
      begin
        repeat (20) @(posedge clock_in);
        #2;
        chk({7'h00, got_done}, 8'h00);
        chk({7'h00, conflict}, 8'h01);
        // no write pulse may start while the flag holds the port off
        chk({7'h00, pins.rw}, 8'h01);
        rsel_n = 1'b1;
      end
    join
    xfer(1'b0, a, 8'h00);
    chk(rdata, expect_rd(a));
    // left selects first: the later right port takes the flag, left read runs
    fork
      xfer(1'b0, used[7], 8'h00);
      begin
        @(negedge pins.sel_n);
        // right follows a full cycle later, far beyond the priority set-up lead
        @(posedge clock_in);
        #2;
        raddr = used[7];
        rsel_n = 1'b0;
      end
    join
    chk(rdata, expect_rd(used[7]));
    chk({7'h00, conflict}, 8'h00);
    rsel_n = 1'b1;
    end_sim();
  end
endmodule : dpc_host_tb
`default_nettype wire
